// [serial_offset_offload_framer.sv]
// Offset packet framer answering request characters on a serial link
//
// Behaviour
// - Only transmit and receive data used; no modem or flow-control lines.
// - Baud rate, parity, stop bits, character length held as settings.
// - One whole packet per request; never sent unsolicited.
// - No acknowledge within 5 s of a request raises an error.
// - Acknowledge clears held offset data.
// - Order: start, length, status, count, fields, end, check byte.
// - First byte is 02H.
// - Length is three ASCII digits, whole packet bytes, MSD first.
// - Length equals offsets times ten plus nine.
// - Status 47H good, 42H bad, 52H rework.
// - Count is two ASCII digits, values 1 to 16 only.
// - Each field ten ASCII bytes, sign first, space padded right.
// - All fields same format, ascending offset order.
// - End character 03H follows last field; only check byte after.
// - Check byte XORs length digit one through end character.
`timescale 1ns/1ps
module serial_offset_offload_framer #(
   parameter longint ACK_TIMEOUT_CYCLES =
      serial_framer_pkg::ACK_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_tx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_off_wr,
   input wire logic [3:0] i_off_index,
   input wire logic [79:0] i_off_data,
   input wire logic i_commit,
   input wire logic [4:0] i_commit_count,
   input wire logic [1:0] i_commit_status,
   input wire logic i_err_clr,
   input wire logic i_cfg_wr,
   input wire logic [15:0] i_cfg_baud_div,
   input wire logic [1:0] i_cfg_parity,
   input wire logic i_cfg_stop2,
   input wire logic [1:0] i_cfg_char_len,
   output logic [15:0] o_baud_div,
   output logic [1:0] o_parity,
   output logic o_stop2,
   output logic [1:0] o_char_len,
   output logic o_data_held,
   output logic o_sending,
   output logic o_awaiting_ack,
   output logic o_comm_err
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEND,
      ST_WAIT
   } state_t;

   state_t state;
   logic [79:0] field_mem [serial_framer_pkg::MAX_OFFSETS];
   logic [4:0] count;
   logic [7:0] pkt_len;
   logic [7:0] status_code;
   logic [7:0] pos;
   logic [7:0] bcc;
   logic [26:0] timer;
   logic [7:0] next_byte;
   logic [7:0] next_pos;
   logic [7:0] field_off;
   logic [3:0] field_num;
   logic [3:0] field_byte;
   logic take;
   logic got_req;
   logic got_ack;
   logic timeout;
   logic last_byte;

   // ****************************************
   // Helpers
   // ****************************************
   // One ASCII decimal digit; place 2 hundreds, 1 tens, 0 units
   function automatic logic [7:0] dig(input logic [7:0] v,
                                      input logic [1:0] place);
      logic [7:0] d;
      d = 8'h00;
      case (place)
         2'h2: d = v / 8'd100;
         2'h1: d = (v / 8'd10) % 8'd10;
         default: d = v % 8'd10;
      endcase
      return serial_framer_pkg::CHAR_ZERO + d;
   endfunction

   assign got_req = i_rx_valid &&
                    (i_rx_data == serial_framer_pkg::CHAR_REQUEST);
   assign got_ack = i_rx_valid && (i_rx_data == serial_framer_pkg::CHAR_ACK);
   assign take = o_tx_valid && i_tx_ready;
   assign last_byte = (pos == pkt_len - 8'h01);
   assign timeout = (state != ST_IDLE) &&
                    (timer == 27'(ACK_TIMEOUT_CYCLES - 1));
   assign next_pos = pos + 8'h01;
   assign field_off = next_pos - serial_framer_pkg::POS_FIRST_FIELD;
   assign field_num = 4'(field_off / 8'd10);
   assign field_byte = 4'(field_off % 8'd10);

   // ****************************************
   // Byte selection for the following position
   // ****************************************
   // packet byte order
   always_comb begin
      next_byte = serial_framer_pkg::CHAR_SPACE;
      if (next_pos == serial_framer_pkg::POS_LEN_HI) begin
         next_byte = dig(pkt_len, 2'h2);
      end else if (next_pos == serial_framer_pkg::POS_LEN_MID) begin
         next_byte = dig(pkt_len, 2'h1);
      end else if (next_pos == serial_framer_pkg::POS_LEN_LO) begin
         next_byte = dig(pkt_len, 2'h0);
      end else if (next_pos == serial_framer_pkg::POS_STATUS) begin
         next_byte = status_code;
      end else if (next_pos == serial_framer_pkg::POS_CNT_HI) begin
         next_byte = dig({3'h0, count}, 2'h1);
      end else if (next_pos == serial_framer_pkg::POS_CNT_LO) begin
         next_byte = dig({3'h0, count}, 2'h0);
      end else if (next_pos == pkt_len - 8'h02) begin
         next_byte = serial_framer_pkg::CHAR_END;
      end else if (next_pos == pkt_len - 8'h01) begin
         next_byte = bcc ^ o_tx_data;
      end else begin
         // ascending fields, byte one sent first
         next_byte = field_mem[field_num][8'd79 - {field_byte, 3'h0} -: 8];
      end
   end

   // ****************************************
   // Protocol state and transmit
   // ****************************************
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         pos <= 8'h00;
         bcc <= 8'h00;
         o_tx_valid <= 1'b0;
         o_tx_data <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               // only on request with data held
               if (got_req && o_data_held) begin
                  state <= ST_SEND;
                  pos <= 8'h00;
                  bcc <= 8'h00;
                  o_tx_valid <= 1'b1;
                  o_tx_data <= serial_framer_pkg::CHAR_START;
               end
            end
            ST_SEND: begin
               if (timeout) begin
                  state <= ST_IDLE;
                  o_tx_valid <= 1'b0;
               end else if (take) begin
                  if (last_byte) begin
                     state <= ST_WAIT;
                     o_tx_valid <= 1'b0;
                  end else begin
                     pos <= next_pos;
                     o_tx_data <= next_byte;
                     if (pos != 8'h00) begin
                        bcc <= bcc ^ o_tx_data;
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (got_ack || timeout) begin
                  state <= ST_IDLE;
               end else if (got_req) begin
                  state <= ST_SEND;
                  pos <= 8'h00;
                  bcc <= 8'h00;
                  o_tx_valid <= 1'b1;
                  o_tx_data <= serial_framer_pkg::CHAR_START;
               end
            end
            default: begin
               state <= ST_IDLE;
               o_tx_valid <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Acknowledge timer
   // ****************************************
   // timed from the request
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         timer <= 27'h0000000;
      end else if (state == ST_IDLE || timeout) begin
         timer <= 27'h0000000;
      end else if (state == ST_WAIT && got_req) begin
         timer <= 27'h0000000;
      end else begin
         timer <= timer + 27'h0000001;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_comm_err <= 1'b0;
      end else if (timeout) begin
         // raise error; set wins over clear
         o_comm_err <= 1'b1;
      end else if (i_err_clr) begin
         o_comm_err <= 1'b0;
      end
   end

   // ****************************************
   // Held offset data
   // ****************************************
   // Writes only in idle so a resend carries identical bytes
   always_ff @(posedge i_ref_clk) begin
      if (i_off_wr && state == ST_IDLE) begin
         field_mem[i_off_index] <= i_off_data;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_data_held <= 1'b0;
         count <= 5'h00;
         pkt_len <= serial_framer_pkg::OVERHEAD_BYTES;
         status_code <= serial_framer_pkg::STATUS_GOOD;
      end else if (state == ST_WAIT && got_ack) begin
         o_data_held <= 1'b0;
         count <= 5'h00;
         pkt_len <= serial_framer_pkg::OVERHEAD_BYTES;
      end else if (i_commit && state == ST_IDLE &&
                   i_commit_count >= serial_framer_pkg::MIN_COUNT &&
                   i_commit_count <= serial_framer_pkg::MAX_COUNT) begin
         o_data_held <= 1'b1;
         count <= i_commit_count;
         pkt_len <= 8'({3'h0, i_commit_count} * 8'd10) +
                    serial_framer_pkg::OVERHEAD_BYTES;
         case (i_commit_status)
            serial_framer_pkg::PART_BAD:
               status_code <= serial_framer_pkg::STATUS_BAD;
            serial_framer_pkg::PART_REWORK:
               status_code <= serial_framer_pkg::STATUS_REWORK;
            default:
               status_code <= serial_framer_pkg::STATUS_GOOD;
         endcase
      end
   end

   // ****************************************
   // Character format settings and status
   // ****************************************
   // settings held for the character framer
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_baud_div <= serial_framer_pkg::BAUD_DIV_RESET;
         o_parity <= serial_framer_pkg::PARITY_RESET;
         o_stop2 <= serial_framer_pkg::STOP2_RESET;
         o_char_len <= serial_framer_pkg::CHAR_LEN_RESET;
      end else if (i_cfg_wr) begin
         o_baud_div <= i_cfg_baud_div;
         o_parity <= i_cfg_parity;
         o_stop2 <= i_cfg_stop2;
         o_char_len <= i_cfg_char_len;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sending <= 1'b0;
         o_awaiting_ack <= 1'b0;
      end else begin
         o_sending <= (state == ST_SEND);
         o_awaiting_ack <= (state == ST_WAIT);
      end
   end
endmodule

// [serial_framer_pkg.sv]
// Constants shared by the serial offset offload framer
package serial_framer_pkg;
   // ****************************************
   // Protocol characters
   // ****************************************
   localparam logic [7:0] CHAR_REQUEST = 8'h11;
   localparam logic [7:0] CHAR_ACK = 8'h13;
   localparam logic [7:0] CHAR_START = 8'h02;
   localparam logic [7:0] CHAR_END = 8'h03;
   localparam logic [7:0] CHAR_SPACE = 8'h20;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [7:0] STATUS_GOOD = 8'h47;
   localparam logic [7:0] STATUS_BAD = 8'h42;
   localparam logic [7:0] STATUS_REWORK = 8'h52;

   // ****************************************
   // Packet layout
   // ****************************************
   localparam int FIELD_BYTES = 10;
   localparam int FIELD_BITS = 80;
   localparam int MAX_OFFSETS = 16;
   localparam logic [4:0] MIN_COUNT = 5'h01;
   localparam logic [4:0] MAX_COUNT = 5'h10;
   localparam logic [7:0] OVERHEAD_BYTES = 8'h09;
   localparam logic [7:0] POS_LEN_HI = 8'h01;
   localparam logic [7:0] POS_LEN_MID = 8'h02;
   localparam logic [7:0] POS_LEN_LO = 8'h03;
   localparam logic [7:0] POS_STATUS = 8'h04;
   localparam logic [7:0] POS_CNT_HI = 8'h05;
   localparam logic [7:0] POS_CNT_LO = 8'h06;
   localparam logic [7:0] POS_FIRST_FIELD = 8'h07;

   typedef enum logic [1:0] {
      PART_GOOD,
      PART_BAD,
      PART_REWORK
   } part_status_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam longint CLK_HZ = 25000000;
   localparam longint ACK_TIMEOUT_S = 5;
   localparam longint ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_S * CLK_HZ;

   // ****************************************
   // Character format reset values
   // ****************************************
   localparam logic [15:0] BAUD_DIV_RESET = 16'h00a3;
   localparam logic [1:0] PARITY_RESET = 2'h0;
   localparam logic STOP2_RESET = 1'b0;
   localparam logic [1:0] CHAR_LEN_RESET = 2'h3;
endpackage

// [framer_checker_properties.sv]
// Port assertions for the offset packet framer
`timescale 1ns/1ps
module framer_checker #(
   parameter longint ACK_TIMEOUT_CYCLES = 200
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_tx_ready,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic i_commit,
   input wire logic [4:0] i_commit_count,
   input wire logic i_err_clr,
   input wire logic i_cfg_wr,
   input wire logic [15:0] i_cfg_baud_div,
   input wire logic [1:0] i_cfg_parity,
   input wire logic [15:0] o_baud_div,
   input wire logic [1:0] o_parity,
   input wire logic o_data_held,
   input wire logic o_sending,
   input wire logic o_awaiting_ack,
   input wire logic o_comm_err
);
   // ****************************************
   // Helper logic
   // ****************************************
   logic req;
   logic idle;
   longint since_req;
   assign req = i_rx_valid && i_rx_data == 8'h11;
   assign idle = !o_sending && !o_awaiting_ack && !o_tx_valid;
   // Ignored requests mid-packet would also reset this; bench avoids them
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst)
         since_req <= 0;
      else if (req)
         since_req <= 0;
      else
         since_req <= since_req + 1;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // ****************************************
   // Assertions
   // ****************************************
   start_byte_a: assert property (req && o_data_held && !o_sending
      && !o_tx_valid |=> o_tx_valid && o_tx_data == 8'h02)
      else $error("packet did not open with start byte");
   no_unsolicited_a: assert property ($rose(o_tx_valid) |->
      $past(req)) else $error("byte offered without request");
   byte_stands_a: assert property (o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_data)) else $error("byte not held");
   ack_clear_a: assert property (i_rx_valid && i_rx_data == 8'h13
      && o_awaiting_ack && !o_tx_valid |=> !o_data_held ##1
      !o_awaiting_ack) else $error("ack did not clear held data");
   err_timing_a: assert property ($rose(o_comm_err) |-> o_data_held
      && since_req == ACK_TIMEOUT_CYCLES) else $error("error mistimed");
   sending_flag_a: assert property ($rose(o_tx_valid) |=>
      o_sending) else $error("sending flag not raised");
   err_clear_a: assert property (i_err_clr && idle |=> !o_comm_err)
      else $error("error flag not cleared");
   cfg_load_a: assert property (i_cfg_wr |=> o_baud_div ==
      $past(i_cfg_baud_div) && o_parity == $past(i_cfg_parity))
      else $error("settings not loaded");
   other_char_a: assert property (i_rx_valid && i_rx_data != 8'h11
      && i_rx_data != 8'h13 && !i_commit |=> $stable(o_data_held))
      else $error("stray character changed held data");
   commit_a: assert property (i_commit && idle && i_commit_count >= 1
      && i_commit_count <= 16 |=> o_data_held) else $error("commit lost");
endmodule
bind serial_offset_offload_framer framer_checker #(
   .ACK_TIMEOUT_CYCLES(ACK_TIMEOUT_CYCLES)
) framer_checker_inst (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
   .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_commit(i_commit),
   .i_commit_count(i_commit_count), .i_err_clr(i_err_clr),
   .i_cfg_wr(i_cfg_wr), .i_cfg_baud_div(i_cfg_baud_div),
   .i_cfg_parity(i_cfg_parity), .o_baud_div(o_baud_div),
   .o_parity(o_parity), .o_data_held(o_data_held),
   .o_sending(o_sending), .o_awaiting_ack(o_awaiting_ack),
   .o_comm_err(o_comm_err));

// [cnc_model.sv]
// Machine tool model on the far side of the framer link
`timescale 1ns/1ps
module cnc_model (
   input wire logic i_ref_clk,
   input wire logic i_slow,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data
);
   logic [7:0] got[$];
   logic ph = 1'b0;
   initial begin
      o_tx_ready = 1'b1;
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
   end
   always @(posedge i_ref_clk) begin
      if (i_tx_valid && o_tx_ready)
         got.push_back(i_tx_data);
      ph <= !ph;
      o_tx_ready <= !i_slow || ph;
   end
   task automatic send(logic [7:0] c);
      @(posedge i_ref_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= c;
      @(posedge i_ref_clk);
      o_rx_valid <= 1'b0;
      // Stale data never looks valid
      o_rx_data <= ~c;
   endtask
endmodule

// [serial_offset_offload_framer_bench.sv]
// Self-checking bench for the offset packet framer
`timescale 1ns/1ps
module serial_offset_offload_framer_bench;
   localparam longint T = 600;
   logic i_ref_clk = 1'b0;
   logic i_rst;
   logic slow = 1'b0;
   wire i_tx_ready;
   wire i_rx_valid;
   wire [7:0] i_rx_data;
   logic o_tx_valid, o_stop2, o_data_held, o_sending, o_awaiting_ack;
   logic o_comm_err, i_cfg_stop2;
   logic [7:0] o_tx_data;
   logic i_off_wr, i_commit, i_err_clr;
   logic i_cfg_wr;
   logic [3:0] i_off_index;
   logic [79:0] i_off_data;
   logic [4:0] i_commit_count;
   logic [1:0] i_commit_status, i_cfg_parity;
   logic [1:0] i_cfg_char_len, o_parity, o_char_len;
   logic [15:0] i_cfg_baud_div, o_baud_div;
   int n_errors = 0;
   int tests_run = 0;
   serial_offset_offload_framer #(.ACK_TIMEOUT_CYCLES(T))
      serial_offset_offload_framer_inst (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
      .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .i_off_wr(i_off_wr), .i_off_index(i_off_index),
      .i_off_data(i_off_data), .i_commit(i_commit),
      .i_commit_count(i_commit_count), .i_commit_status(i_commit_status),
      .i_err_clr(i_err_clr), .i_cfg_wr(i_cfg_wr),
      .i_cfg_baud_div(i_cfg_baud_div), .i_cfg_parity(i_cfg_parity),
      .i_cfg_stop2(i_cfg_stop2), .i_cfg_char_len(i_cfg_char_len),
      .o_baud_div(o_baud_div), .o_parity(o_parity), .o_stop2(o_stop2),
      .o_char_len(o_char_len), .o_data_held(o_data_held),
      .o_sending(o_sending), .o_awaiting_ack(o_awaiting_ack),
      .o_comm_err(o_comm_err));
   cnc_model cnc_model_inst (.i_ref_clk(i_ref_clk), .i_slow(slow),
      .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
      .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid),
      .o_rx_data(i_rx_data));
   initial forever #20 i_ref_clk = ~i_ref_clk;
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic cyc(int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   function automatic logic [79:0] fld(int i);
      return {((i % 2 == 1) ? 8'h2d : 8'h2b), 8'h30, 8'h2e,
         8'h30 + 8'(i / 10), 8'h30 + 8'(i % 10), {5{8'h20}}};
   endfunction
   task automatic commit(int n, logic [1:0] st);
      @(posedge i_ref_clk);
      i_off_wr <= 1'b0;
      i_commit <= 1'b1;
      i_commit_count <= 5'(n);
      i_commit_status <= st;
      @(posedge i_ref_clk);
      i_commit <= 1'b0;
   endtask
   task automatic load(int n, logic [1:0] st);
      for (int i = 0; i < n; i++) begin
         @(posedge i_ref_clk);
         i_off_wr <= 1'b1;
         i_off_index <= 4'(i);
         i_off_data <= fld(i);
      end
      commit(n, st);
   endtask
   task automatic fetch(int n, logic [1:0] st);
      logic [7:0] e[$];
      logic [7:0] x;
      logic [79:0] f;
      int len;
      len = n * 10 + 9;
      x = st == 2'h1 ? 8'h42 : st == 2'h2 ? 8'h52 : 8'h47;
      e = {8'h02, 8'h30 + 8'(len / 100), 8'h30 + 8'(len / 10 % 10),
         8'h30 + 8'(len % 10), x, 8'h30 + 8'(n / 10), 8'h30 + 8'(n % 10)};
      for (int i = 0; i < n * 10; i++) begin
         f = fld(i / 10);
         e.push_back(f[79 - 8 * (i % 10) -: 8]);
      end
      e.push_back(8'h03);
      x = 8'h00;
      for (int i = 1; i < len - 1; i++)
         x ^= e[i];
      e.push_back(x);
      cnc_model_inst.got.delete();
      cnc_model_inst.send(8'h11);
      for (int w = 0; w < 2000 && cnc_model_inst.got.size() < len; w++)
         cyc(1);
      cyc(3);
      check("count", 8'(len), 8'(cnc_model_inst.got.size()));
      for (int i = 0; i < 4; i++)
         check("head", e[i], cnc_model_inst.got[i]);
      for (int i = 4; i < 7; i++)
         check("status", e[i], cnc_model_inst.got[i]);
      for (int i = 7; i < len - 2; i++)
         check("field", e[i], cnc_model_inst.got[i]);
      for (int i = len - 2; i < len; i++)
         check("tail", e[i], cnc_model_inst.got[i]);
      check("awaiting", 8'h01, 8'(o_awaiting_ack));
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_settings;
      check("baud", 8'ha3, o_baud_div[7:0]);
      check("len", 8'h03, 8'(o_char_len));
      @(posedge i_ref_clk);
      i_cfg_wr <= 1'b1;
      i_cfg_baud_div <= 16'h1234;
      i_cfg_parity <= 2'h2;
      i_cfg_stop2 <= 1'b1;
      i_cfg_char_len <= 2'h1;
      @(posedge i_ref_clk);
      i_cfg_wr <= 1'b0;
      cyc(1);
      check("baud", 8'h12, o_baud_div[15:8]);
      check("cfg", 8'h29, {o_parity, o_stop2, 1'b0, o_char_len});
      $display("done settings");
   endtask
   task automatic t_refused;
      cnc_model_inst.send(8'h11);
      commit(17, 2'h0);
      commit(0, 2'h0);
      cnc_model_inst.send(8'h41);
      cyc(4);
      check("tx", 8'h00, 8'(o_tx_valid));
      check("held", 8'h00, 8'(o_data_held));
      $display("done refused");
   endtask
   task automatic t_packets;
      int ns[4] = '{2, 16, 1, 5};
      for (int i = 0; i < 4; i++) begin
         slow <= (i == 1);
         load(ns[i], 2'(i + 1));
         fetch(ns[i], 2'(i + 1));
         cnc_model_inst.send(8'h13);
         cyc(1);
         check("held", 8'h00, 8'(o_data_held));
      end
      slow <= 1'b0;
      $display("done packets");
   endtask
   task automatic t_resend;
      load(3, 2'h1);
      fetch(3, 2'h1);
      cnc_model_inst.send(8'h41);
      cyc(2);
      check("wait", 8'h01, 8'(o_awaiting_ack & o_data_held));
      fetch(3, 2'h1);
      cnc_model_inst.send(8'h13);
      $display("done resend");
   endtask
   task automatic t_timeout;
      load(1, 2'h0);
      fetch(1, 2'h0);
      cyc(T / 2);
      fetch(1, 2'h0);
      cyc(T - 60);
      check("early", 8'h00, 8'(o_comm_err));
      cyc(80);
      check("err", 8'h03, {o_comm_err, o_data_held});
      fetch(1, 2'h0);
      cnc_model_inst.send(8'h13);
      @(posedge i_ref_clk);
      i_err_clr <= 1'b1;
      @(posedge i_ref_clk);
      i_err_clr <= 1'b0;
      cyc(1);
      check("clear", 8'h00, 8'(o_comm_err));
      $display("done timeout");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      n_errors++;
      close_out;
   end
   initial begin
      i_rst <= 1'b1;
      i_off_wr <= 1'b0;
      i_commit <= 1'b0;
      i_err_clr <= 1'b0;
      i_cfg_wr <= 1'b0;
      i_off_index <= 4'h0;
      i_off_data <= 80'h0;
      i_commit_count <= 5'h0;
      i_commit_status <= 2'h0;
      i_cfg_parity <= 2'h0;
      i_cfg_char_len <= 2'h0;
      i_cfg_baud_div <= 16'h0;
      i_cfg_stop2 <= 1'b0;
      cyc(8);
      i_rst <= 1'b0;
      cyc(1);
      t_settings;
      t_refused;
      t_packets;
      t_resend;
      t_timeout;
      close_out;
   end
endmodule
